/* design/lce_pkg.sv */
// Constants and types for the link control and equalizer register pair
// Operation
// R1: Reg 0x04 bits 3:2 pick local channel: 00 I2C, 01 UART, 1x off; reset 01
// R2: Reg 0x04 bit 1 enables sending control channel toward serializer; reset 1
// R3: Reg 0x04 bit 0 enables receiving control channel from serializer; reset 1
// R4: Reg 0x05 bit 7 set omits register address in UART-to-I2C; reset 0
// R5: Reg 0x05 bit 6 selects boosted output drive current; reset 0
// R6: Reg 0x05 bit 5 selects full periodic sync tracking; reset 1
// R7: Reg 0x05 bit 4 enables equalizer; disabled after reset
// R8: Reg 0x05 bits 3:0 boost step 0..11, reset 1001; codes 11XX never used
// R9: Reg 0x04 bit 7 reads current lock level; writes ignored
package lce_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] LCE_ADDR_CTRL = 8'h04;
	localparam logic [7:0] LCE_ADDR_CONF = 8'h05;
	localparam logic [7:0] LCE_RD_UNMAPPED = 8'h00;

	// ==========================================================
	// Field positions, register 0x04
	localparam int LCE_LOCK_BIT  = 7;
	localparam int LCE_ODIS_BIT  = 6;
	localparam int LCE_PTST_BIT  = 5;
	localparam int LCE_SLEEP_BIT = 4;
	localparam int LCE_TYPE_HI   = 3;
	localparam int LCE_TYPE_LO   = 2;
	localparam int LCE_SEND_BIT  = 1;
	localparam int LCE_RECV_BIT  = 0;

	// ==========================================================
	// Field positions, register 0x05
	localparam int LCE_OMIT_BIT  = 7;
	localparam int LCE_DRV_BIT   = 6;
	localparam int LCE_TRK_BIT   = 5;
	localparam int LCE_EQEN_BIT  = 4;
	localparam int LCE_BOOST_HI  = 3;
	localparam int LCE_BOOST_LO  = 0;

	// ==========================================================
	// Channel type codes and reset values
	localparam logic [1:0] LCE_TYPE_I2C  = 2'h0;
	localparam logic [1:0] LCE_TYPE_UART = 2'h1;
	localparam logic [1:0] LCE_BOOST_BAD = 2'h3;
	localparam logic [6:0] LCE_CTRL_RST  = 7'h07;
	localparam logic [7:0] LCE_CONF_RST  = 8'h29;

	typedef struct packed {
		logic [6:0] ctrl;
		logic [7:0] conf;
		logic [1:0] lock_sync;
		logic [1:0] isel_sync;
		logic [7:0] rdata;
		logic       rvalid;
	} lce_state_t;

endpackage : lce_pkg

/* design/lce_regs.sv */
// Link status, channel control and equalizer configuration registers
`timescale 1ns/1ns
`default_nettype none
module lce_regs (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        link_lock_status,
	input  wire logic        interface_select_input,
	output logic             output_disable,
	output logic             pattern_test_enable,
	output logic             sleep_request,
	output logic      [1:0]  local_channel_type,
	output logic             local_i2c_active,
	output logic             local_uart_active,
	output logic             send_channel_enable,
	output logic             receive_channel_enable,
	output logic             conversion_address_omit,
	output logic             drive_boost_select,
	output logic             sync_tracking_style,
	output logic             equalizer_enable,
	output logic      [3:0]  equalizer_boost_code
);
	import lce_pkg::*;

	lce_state_t st_r;
	lce_state_t st_nxt;
	logic       wr_ctrl;
	logic       wr_conf;
	logic       lock_now;
	logic       isel_now;
	logic [6:0] ctrl_view;
	logic [7:0] conf_view;

	assign wr_ctrl  = reg_wr && (reg_addr == LCE_ADDR_CTRL);
	assign wr_conf  = reg_wr && (reg_addr == LCE_ADDR_CONF);
	assign lock_now = st_r.lock_sync[1];
	assign isel_now = st_r.isel_sync[1];

	// ==========================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.lock_sync = {st_r.lock_sync[0], link_lock_status};
		st_nxt.isel_sync = {st_r.isel_sync[0], interface_select_input};
		if (wr_ctrl) begin
			// Lock bit is not stored; only bits 6:0 take the write
			st_nxt.ctrl = reg_wdata[LCE_ODIS_BIT:0]; // R1 R2 R3 R9
		end
		if (wr_conf) begin
			st_nxt.conf[LCE_OMIT_BIT:LCE_EQEN_BIT] =
				reg_wdata[LCE_OMIT_BIT:LCE_EQEN_BIT]; // R4 R5 R6 R7
			// Illegal boost codes leave the previous step in place
			if (reg_wdata[LCE_BOOST_HI -: 2] != LCE_BOOST_BAD) begin
				st_nxt.conf[LCE_BOOST_HI:LCE_BOOST_LO] =
					reg_wdata[LCE_BOOST_HI:LCE_BOOST_LO]; // R8
			end
		end
		st_nxt.rvalid = reg_rd;
		if (reg_rd) begin
			unique case (reg_addr)
				LCE_ADDR_CTRL: st_nxt.rdata = {lock_now, st_r.ctrl}; // R9
				LCE_ADDR_CONF: st_nxt.rdata = st_r.conf;
				default:       st_nxt.rdata = LCE_RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r.ctrl      <= LCE_CTRL_RST; // R1 R2 R3
			st_r.conf      <= LCE_CONF_RST; // R4 R5 R6 R7 R8
			st_r.lock_sync <= 2'h0;
			st_r.isel_sync <= 2'h0;
			st_r.rdata     <= 8'h00;
			st_r.rvalid    <= 1'h0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata               = st_r.rdata;
	assign reg_rvalid              = st_r.rvalid;
	assign output_disable          = st_r.ctrl[LCE_ODIS_BIT];
	assign pattern_test_enable     = st_r.ctrl[LCE_PTST_BIT];
	assign sleep_request           = st_r.ctrl[LCE_SLEEP_BIT];
	assign local_channel_type      = st_r.ctrl[LCE_TYPE_HI:LCE_TYPE_LO];
	assign local_i2c_active        = !isel_now &&
		(local_channel_type == LCE_TYPE_I2C); // R1
	assign local_uart_active       = !isel_now &&
		(local_channel_type == LCE_TYPE_UART); // R1
	assign send_channel_enable     = st_r.ctrl[LCE_SEND_BIT];
	assign receive_channel_enable  = st_r.ctrl[LCE_RECV_BIT];
	assign conversion_address_omit = st_r.conf[LCE_OMIT_BIT];
	assign drive_boost_select      = st_r.conf[LCE_DRV_BIT];
	assign sync_tracking_style     = st_r.conf[LCE_TRK_BIT];
	assign equalizer_enable        = st_r.conf[LCE_EQEN_BIT];
	assign equalizer_boost_code    = st_r.conf[LCE_BOOST_HI:LCE_BOOST_LO];

	// Field views shared by the read-path checks
	assign ctrl_view = {output_disable, pattern_test_enable, sleep_request,
		local_channel_type, send_channel_enable, receive_channel_enable};
	assign conf_view = {conversion_address_omit, drive_boost_select,
		sync_tracking_style, equalizer_enable, equalizer_boost_code};

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_wr_ctrl;
		reg_wr && reg_addr == LCE_ADDR_CTRL;
	endsequence
	sequence s_wr_conf;
		reg_wr && reg_addr == LCE_ADDR_CONF;
	endsequence

	chk_type_write: assert property (s_wr_ctrl |=> // R1
		local_channel_type == $past(reg_wdata[LCE_TYPE_HI:LCE_TYPE_LO]))
		else $error("channel type not taken from write");
	chk_local_excl: assert property ( // R1
		!(local_i2c_active && local_uart_active))
		else $error("both local channels active");
	chk_local_off: assert property (local_channel_type[1] |-> // R1
		!local_i2c_active && !local_uart_active)
		else $error("local channel active while disabled");
	chk_send_write: assert property (s_wr_ctrl |=> // R2
		send_channel_enable == $past(reg_wdata[LCE_SEND_BIT]))
		else $error("send enable not taken");
	chk_recv_write: assert property (s_wr_ctrl |=> // R3
		receive_channel_enable == $past(reg_wdata[LCE_RECV_BIT]))
		else $error("receive enable not taken");
	chk_omit_write: assert property (s_wr_conf |=> // R4
		conversion_address_omit == $past(reg_wdata[LCE_OMIT_BIT]))
		else $error("address omit not taken");
	chk_drive_hold: assert property (!reg_wr |=> // R5
		$stable(drive_boost_select) && $stable(sync_tracking_style))
		else $error("drive or tracking changed without write");
	chk_track_write: assert property (s_wr_conf |=> // R6
		sync_tracking_style == $past(reg_wdata[LCE_TRK_BIT]) &&
		drive_boost_select == $past(reg_wdata[LCE_DRV_BIT])) // R5
		else $error("tracking or drive not taken");
	chk_eq_write: assert property (s_wr_conf |=> // R7
		equalizer_enable == $past(reg_wdata[LCE_EQEN_BIT]))
		else $error("equalizer enable not taken");
	chk_boost_legal: assert property ( // R8
		equalizer_boost_code[LCE_BOOST_HI -: 2] != LCE_BOOST_BAD)
		else $error("illegal boost code held");
	chk_lock_read: assert property (reg_rd && reg_addr == LCE_ADDR_CTRL |=> // R9
		reg_rvalid && reg_rdata[LCE_LOCK_BIT] == $past(lock_now))
		else $error("lock bit read mismatch");

	// ==========================================================
	// Checks on the pin synchronisers and the read path
	sequence s_lock_high;
		link_lock_status [*3];
	endsequence
	sequence s_lock_low;
		!link_lock_status [*3];
	endsequence
	sequence s_isel_high;
		interface_select_input [*3];
	endsequence
	sequence s_isel_low;
		!interface_select_input [*3];
	endsequence
	sequence s_rd_ctrl;
		reg_rd && reg_addr == LCE_ADDR_CTRL;
	endsequence
	sequence s_rd_conf;
		reg_rd && reg_addr == LCE_ADDR_CONF;
	endsequence

	// A pin steady for three edges has crossed both flops
	chk_lock_high: assert property (s_lock_high |-> lock_now) // R9
		else $error("lock high not synchronised");
	chk_lock_low: assert property (s_lock_low |-> !lock_now) // R9
		else $error("lock low not synchronised");
	chk_isel_high: assert property (s_isel_high |-> // R1
		!local_i2c_active && !local_uart_active)
		else $error("local channel active with select high");
	chk_isel_low: assert property (s_isel_low |-> // R1
		local_uart_active == (local_channel_type == LCE_TYPE_UART) &&
		local_i2c_active == (local_channel_type == LCE_TYPE_I2C))
		else $error("local channel wrong with select low");

	chk_rvalid_set: assert property (reg_rd |=> reg_rvalid) // R9
		else $error("read answer missing");
	chk_rvalid_clear: assert property (!reg_rd |=> !reg_rvalid) // R9
		else $error("read answer without read");
	chk_ctrl_read: assert property (s_rd_ctrl |=> // R1 R2 R3
		reg_rdata[LCE_ODIS_BIT:0] == $past(ctrl_view))
		else $error("control read data mismatch");
	chk_conf_read: assert property (s_rd_conf |=> // R4 R5 R6 R7 R8
		reg_rdata == $past(conf_view))
		else $error("config read data mismatch");
	chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) // R9
		else $error("read data changed without read");

	// Fields move only on a write to their own register
	chk_ctrl_hold: assert property (!wr_ctrl |=> $stable(ctrl_view)) // R2
		else $error("control fields changed without write");
	chk_conf_hold: assert property (!wr_conf |=> // R4 R7 R8
		$stable(conversion_address_omit) && $stable(equalizer_enable) &&
		$stable(equalizer_boost_code))
		else $error("config fields changed without write");
	chk_boost_write: assert property (wr_conf && // R8
		reg_wdata[LCE_BOOST_HI -: 2] != LCE_BOOST_BAD |=>
		equalizer_boost_code == $past(reg_wdata[LCE_BOOST_HI:LCE_BOOST_LO]))
		else $error("legal boost code not taken");
	chk_boost_keep: assert property (wr_conf && // R8
		reg_wdata[LCE_BOOST_HI -: 2] == LCE_BOOST_BAD |=>
		$stable(equalizer_boost_code))
		else $error("illegal boost code changed step");

endmodule : lce_regs
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the link control and equalizer registers
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import lce_pkg::*;
	logic       clk   = 1'b0;
	logic       rstn  = 1'b0;
	logic [7:0] addr  = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr    = 1'b0;
	logic       rd    = 1'b0;
	logic       lock  = 1'b0;
	logic       isel  = 1'b0;
	logic [7:0] rdata;
	logic       rvalid, odis, ptst, slp, i2c, uart, snd, rcv;
	logic       omit, drv, trk, eqen;
	logic [1:0] ctype;
	logic [3:0] boost;
	int         fail_count  = 0;
	int         check_count = 0;
	int         t;

	lce_regs dut (.clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.link_lock_status(lock), .interface_select_input(isel),
		.output_disable(odis), .pattern_test_enable(ptst),
		.sleep_request(slp), .local_channel_type(ctype),
		.local_i2c_active(i2c), .local_uart_active(uart),
		.send_channel_enable(snd), .receive_channel_enable(rcv),
		.conversion_address_omit(omit), .drive_boost_select(drv),
		.sync_tracking_style(trk), .equalizer_enable(eqen),
		.equalizer_boost_code(boost));

	always #2 clk = ~clk;

	// ==========================================================
	// Shared tasks
	task check(input logic [7:0] got, input logic [7:0] exp, input string s);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask : check

	task test_done();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done

	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr  = a;
		wdata = d;
		wr    = 1'b1;
		@(negedge clk);
		wr    = 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [7:0] a, input logic [7:0] exp, input string s);
		int i;
		@(negedge clk);
		addr = a;
		rd   = 1'b1;
		@(negedge clk);
		rd   = 1'b0;
		for (i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clk);
		if (rvalid !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED t=%0t no read answer", $time);
			test_done();
		end else begin
			check(rdata, exp, s);
		end
	endtask : rd_reg

	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		check({4'h0, ctype, snd, rcv}, 8'h07, "ctrl fields reset");
		check({omit, drv, trk, eqen, boost}, 8'h29, "conf reset");
		check({7'h0, eqen}, 8'h00, "eq off at reset");
		rd_reg(LCE_ADDR_CTRL, 8'h07, "ctrl read reset");
		rd_reg(LCE_ADDR_CONF, 8'h29, "conf read reset");
		$display("test reset done");
		for (t = 0; t < 4; t++) begin
			wr_reg(LCE_ADDR_CTRL, {4'hf, t[1:0], 2'h0});
			check({odis, ptst, i2c, uart, snd, rcv, ctype},
				{2'h3, t == 0, t == 1, 2'h0, t[1:0]}, "type");
			check({6'h0, slp, rcv}, 8'h02, "sleep set");
			rd_reg(LCE_ADDR_CTRL, {4'h7, t[1:0], 2'b00}, "lock ro");
		end
		wr_reg(LCE_ADDR_CTRL, 8'h05);
		check({odis, ptst, slp, 2'h0, uart, snd, rcv}, 8'h05, "send off");
		isel = 1'b1;
		repeat (3) @(negedge clk);
		check({6'h0, i2c, uart}, 8'h00, "select high");
		isel = 1'b0;
		wr_reg(LCE_ADDR_CTRL, 8'h06);
		check({6'h0, snd, rcv}, 8'h02, "recv off");
		$display("test control done");
		wr_reg(LCE_ADDR_CONF, 8'hd3);
		check({omit, drv, trk, eqen, boost}, 8'hd3, "conf write");
		wr_reg(LCE_ADDR_CONF, 8'h2c);
		check({omit, drv, trk, eqen, boost}, 8'h23, "bad boost");
		rd_reg(LCE_ADDR_CONF, 8'h23, "conf read");
		$display("test config done");
		lock = 1'b1;
		repeat (3) @(negedge clk);
		rd_reg(LCE_ADDR_CTRL, 8'h86, "lock high");
		wr_reg(8'h06, 8'hff);
		rd_reg(8'h06, 8'h00, "unmapped");
		rd_reg(LCE_ADDR_CTRL, 8'h86, "ctrl kept");
		$display("test lock done");
		test_done();
	end
endmodule : tb_top
`default_nettype wire
